// ### hdl/fsp_pkg.sv
/*
  Shared constants and types of the flash and trusted-module serial port.
  Assumes one 10 MHz system clock; everything else derives from it.
*/
`default_nettype none

package fsp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock rates
  localparam int MCLK_HZ = 10_000_000;
  localparam int RATE_17_HZ = 17_000_000;
  localparam int RATE_30_HZ = 30_000_000;
  localparam int RATE_48_HZ = 48_000_000;
  localparam int DIV_W = 8;
  // Half period of the serial clock, rounded down, never below one cycle
  localparam int HALF_17_I = (MCLK_HZ / (2 * RATE_17_HZ)) < 1 ? 1 : MCLK_HZ / (2 * RATE_17_HZ);
  localparam int HALF_30_I = (MCLK_HZ / (2 * RATE_30_HZ)) < 1 ? 1 : MCLK_HZ / (2 * RATE_30_HZ);
  localparam int HALF_48_I = (MCLK_HZ / (2 * RATE_48_HZ)) < 1 ? 1 : MCLK_HZ / (2 * RATE_48_HZ);
  localparam logic [DIV_W-1:0] HALF_17 = DIV_W'(HALF_17_I);
  localparam logic [DIV_W-1:0] HALF_30 = DIV_W'(HALF_30_I);
  localparam logic [DIV_W-1:0] HALF_48 = DIV_W'(HALF_48_I);
  localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;
  localparam logic [1:0] RATE_SEL_17 = 2'h0;
  localparam logic [1:0] RATE_SEL_30 = 2'h1;
  localparam logic [1:0] RATE_SEL_48 = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Targets and lanes
  localparam int NUM_SEL = 3;
  localparam logic [1:0] TGT_PRI = 2'h0;
  localparam logic [1:0] TGT_SEC = 2'h1;
  localparam logic [1:0] TGT_TPM = 2'h2;
  localparam logic [NUM_SEL-1:0] CS_NONE = 3'h7;
  localparam logic [1:0] LW_1 = 2'h0;
  localparam logic [1:0] LW_2 = 2'h1;
  localparam logic [1:0] LW_4 = 2'h2;
  localparam logic [3:0] DQ_NONE = 4'h0;
  localparam logic [3:0] DQ_L0 = 4'h1;
  localparam logic [3:0] DQ_L01 = 4'h3;
  localparam logic [3:0] DQ_ALL = 4'hf;

  ////////////////////////////////////////////////////////////////////////////
  // Phase lengths in serial clock cycles or bits
  localparam logic [7:0] OPC_CYC = 8'h08;
  localparam logic [7:0] ADDR3_BITS = 8'h18;
  localparam logic [7:0] ADDR4_BITS = 8'h20;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] BITS_ZERO = 4'h0;
  localparam logic [1:0] ADDR_HI_ZERO = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    M_SINGLE = 3'h0,
    M_DUAL_OUT = 3'h1,
    M_DUAL_IO = 3'h2,
    M_QUAD_OUT = 3'h3,
    M_QUAD_IO = 3'h4
  } fsp_mode_t;

  typedef struct packed {
    logic [1:0] rate;
    logic [1:0] target;
    fsp_mode_t mode;
    logic write;
    logic addr4;
    logic [7:0] opcode;
    logic [25:0] addr;
    logic [7:0] dummy;
    logic [7:0] len;
  } fsp_cmd_t;

  typedef struct packed {
    logic clk;
    logic clk_oe_n;
    logic [NUM_SEL-1:0] cs_n;
    logic cs_oe_n;
    logic [3:0] dq;
    logic [3:0] dq_oe_n;
  } fsp_pins_t;

  localparam fsp_pins_t PINS_OFF = '{clk: 1'b0, clk_oe_n: 1'b1, cs_n: CS_NONE,
                                     cs_oe_n: 1'b1, dq: DQ_NONE, dq_oe_n: DQ_ALL};

endpackage

`default_nettype wire

// ### hdl/fsp_clk_div.sv
/*
  Serial clock divider: one-cycle tick per half period of the chosen rate.
  Assumes run_i comes from logic on the same clock.
*/
`default_nettype none

module fsp_clk_div (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic [1:0] rate_i,
  output logic tick_o
);

  logic [fsp_pkg::DIV_W-1:0] cnt_q, cnt_d, half;
  logic tick_d;

  always_comb begin
    case (rate_i)
      fsp_pkg::RATE_SEL_30: half = fsp_pkg::HALF_30;
      fsp_pkg::RATE_SEL_48: half = fsp_pkg::HALF_48;
      default: half = fsp_pkg::HALF_17;
    endcase
    tick_d = 1'b0;
    cnt_d = cnt_q + fsp_pkg::DIV_ONE;
    if (!run_i) begin
      cnt_d = fsp_pkg::DIV_ONE;
    end else if (cnt_q >= half) begin
      cnt_d = fsp_pkg::DIV_ONE;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cnt_q <= fsp_pkg::DIV_ONE;
      tick_o <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_o <= tick_d;
    end
  end

endmodule

`default_nettype wire

// ### hdl/fsp_port.sv
/*
  Master side of the flash and trusted-module serial port, pin level.
  Assumes commands, straps and sleep come from logic on mclk_i; data lanes
  and the resume-well reset are asynchronous pins.
*/
`default_nettype none

// What this block does
// - Exactly three active-low chip selects: two flash, one trusted module.
// - First select reaches only the primary flash device.
// - Second select reaches only the optional secondary flash device.
// - Third select reaches only the trusted module, attached to this port.
// - A strap places the trusted module here or elsewhere; only one exists.
// - Serial clock rate select offers 17, 30, 48 MHz; with the 10 MHz clock every setting gives 5 MHz.
// - Lane zero is a pure output without the bidirectional strap, except in dual output read dummy and data.
// - Lane one is a pure input unless the bidirectional strap is set.
// - Upper lanes serve only quad output and quad I/O modes, unused otherwise.
// - All pins stay tri-stated until the resume-well reset is released.
// - Four multi-lane reads: dual output, dual I/O, quad output, quad I/O.
// - Three-byte addresses reach 16 MB, four-byte addresses reach 64 MB.
module fsp_port (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic resume_well_reset_n_i,
  input wire logic sleep_i,
  input wire logic bidir_strap_i,
  input wire logic tpm_strap_i,
  input wire logic req_valid_i,
  input wire fsp_pkg::fsp_cmd_t req_i,
  output logic req_ready_o,
  input wire logic wr_valid_i,
  input wire logic [7:0] wr_data_i,
  output logic wr_take_o,
  output logic rd_valid_o,
  output logic [7:0] rd_data_o,
  output logic done_o,
  output logic err_o,
  input wire logic [3:0] dq_i,
  output fsp_pkg::fsp_pins_t pins_o
);

  typedef enum logic [2:0] {ST_IDLE, ST_OPC, ST_ADDR, ST_DUMMY, ST_DATA, ST_END} fsp_state_t;

  fsp_state_t state_q, state_d;
  fsp_pkg::fsp_cmd_t cmd_q, cmd_d;
  fsp_pkg::fsp_pins_t pins_d;
  logic [31:0] sh_q, sh_d;
  logic [7:0] cnt_q, cnt_d, left_q, left_d, in_q, in_d, rdd_d;
  logic [3:0] bits_q, bits_d, dq_s1_q, dq_s_q, val, drive;
  logic [2:0] sel_q, sel_d;
  logic [1:0] lwa, lwd, lw_sh, lw_pin;
  logic rsm1_q, rel_q, bidir_q, tpm_q, bidir_d, tpm_d;
  logic need_q, need_d, sclk_q, sclk_d, tick, bad, enter;
  logic ready_d, take_d, rdv_d, done_d, err_d;

  ////////////////////////////////////////////////////////////////////////////
  // Lane width per phase
  function automatic logic [1:0] addr_lw(input fsp_pkg::fsp_mode_t m);
    case (m)
      fsp_pkg::M_DUAL_IO: addr_lw = fsp_pkg::LW_2;
      fsp_pkg::M_QUAD_IO: addr_lw = fsp_pkg::LW_4;
      default: addr_lw = fsp_pkg::LW_1;
    endcase
  endfunction

  function automatic logic [1:0] data_lw(input fsp_pkg::fsp_mode_t m);
    case (m)
      fsp_pkg::M_DUAL_OUT, fsp_pkg::M_DUAL_IO: data_lw = fsp_pkg::LW_2;
      fsp_pkg::M_QUAD_OUT, fsp_pkg::M_QUAD_IO: data_lw = fsp_pkg::LW_4;
      default: data_lw = fsp_pkg::LW_1;
    endcase
  endfunction

  assign lwa = addr_lw(cmd_q.mode);
  assign lwd = data_lw(cmd_q.mode);

  fsp_clk_div u_div (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .run_i(state_q != ST_IDLE && !need_q && rel_q),
    .rate_i(cmd_q.rate),
    .tick_o(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command check
  always_comb begin
    bad = req_i.target == 2'h3 || req_i.mode > fsp_pkg::M_QUAD_IO || req_i.rate == 2'h3;
    if (req_i.target == fsp_pkg::TGT_TPM && (!tpm_q || req_i.mode != fsp_pkg::M_SINGLE)) begin
      bad = 1'b1;
    end
    if (!bidir_q && req_i.mode inside {fsp_pkg::M_DUAL_IO, fsp_pkg::M_QUAD_OUT,
                                       fsp_pkg::M_QUAD_IO}) begin
      bad = 1'b1;
    end
    if (!req_i.addr4 && req_i.addr[25:24] != fsp_pkg::ADDR_HI_ZERO) begin
      bad = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencer
  always_comb begin
    state_d = state_q;
    cmd_d = cmd_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    in_d = in_q;
    bits_d = bits_q;
    left_d = left_q;
    need_d = need_q;
    sclk_d = sclk_q;
    sel_d = sel_q;
    rdd_d = rd_data_o;
    rdv_d = 1'b0;
    take_d = 1'b0;
    done_d = 1'b0;
    err_d = 1'b0;
    enter = 1'b0;
    bidir_d = rel_q ? bidir_q : bidir_strap_i;
    tpm_d = rel_q ? tpm_q : tpm_strap_i;
    unique case (state_q)
      ST_IDLE: begin
        sclk_d = 1'b0;
        sel_d = fsp_pkg::CS_NONE;
        if (req_valid_i && req_ready_o) begin
          if (bad) begin
            err_d = 1'b1;
          end else begin
            cmd_d = req_i;
            sh_d = {req_i.opcode, 24'h0};
            cnt_d = fsp_pkg::OPC_CYC;
            state_d = ST_OPC;
            sel_d[req_i.target] = 1'b0;
          end
        end
      end
      ST_END: begin
        if (tick) begin
          sel_d = fsp_pkg::CS_NONE;
          done_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
      ST_OPC, ST_ADDR, ST_DUMMY, ST_DATA: begin
        if (need_q) begin
          if (wr_valid_i) begin
            sh_d = {wr_data_i, 24'h0};
            cnt_d = fsp_pkg::OPC_CYC;
            need_d = 1'b0;
            take_d = 1'b1;
          end
        end else if (tick && !sclk_q) begin
          sclk_d = 1'b1;
          if (state_q == ST_DATA && !cmd_q.write) begin
            unique case (lwd)
              fsp_pkg::LW_2: in_d = {in_q[5:0], dq_s_q[1:0]};
              fsp_pkg::LW_4: in_d = {in_q[3:0], dq_s_q};
              default: in_d = {in_q[6:0], dq_s_q[1]};
            endcase
            bits_d = bits_q + (4'h1 << lwd);
            if (bits_d == fsp_pkg::BYTE_BITS) begin
              rdv_d = 1'b1;
              rdd_d = in_d;
              bits_d = fsp_pkg::BITS_ZERO;
              left_d = left_q - fsp_pkg::CNT_ONE;
            end
          end
        end else if (tick) begin
          sclk_d = 1'b0;
          if (state_q == ST_DATA && !cmd_q.write) begin
            if (left_q == fsp_pkg::CNT_ZERO) begin
              state_d = ST_END;
            end
          end else if (cnt_q != fsp_pkg::CNT_ONE) begin
            cnt_d = cnt_q - fsp_pkg::CNT_ONE;
            sh_d = sh_q << (6'h1 << lw_sh);
          end else begin
            unique case (state_q)
              ST_OPC: begin
                state_d = ST_ADDR;
                sh_d = cmd_q.addr4 ? {6'h0, cmd_q.addr} : {cmd_q.addr[23:0], 8'h0};
                cnt_d = (cmd_q.addr4 ? fsp_pkg::ADDR4_BITS : fsp_pkg::ADDR3_BITS) >> lwa;
              end
              ST_ADDR: begin
                if (cmd_q.dummy != fsp_pkg::CNT_ZERO) begin
                  state_d = ST_DUMMY;
                  cnt_d = cmd_q.dummy;
                end else begin
                  enter = 1'b1;
                end
              end
              ST_DUMMY: enter = 1'b1;
              default: begin
                left_d = left_q - fsp_pkg::CNT_ONE;
                if (left_q == fsp_pkg::CNT_ONE) begin
                  state_d = ST_END;
                end else begin
                  need_d = 1'b1;
                end
              end
            endcase
          end
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (enter) begin
      left_d = cmd_q.len;
      bits_d = fsp_pkg::BITS_ZERO - (4'h1 << lwd); // First sample predates the pin sync
      state_d = cmd_q.len == fsp_pkg::CNT_ZERO ? ST_END : ST_DATA;
      need_d = cmd_q.write && cmd_q.len != fsp_pkg::CNT_ZERO;
    end
    if (!rel_q) begin
      state_d = ST_IDLE;
      sel_d = fsp_pkg::CS_NONE;
      sclk_d = 1'b0;
      need_d = 1'b0;
    end
    ready_d = rel_q && !sleep_i && state_d == ST_IDLE;
  end

  assign lw_sh = state_q == ST_ADDR ? lwa : fsp_pkg::LW_1;

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive
  always_comb begin
    lw_pin = state_d == ST_ADDR ? lwa : fsp_pkg::LW_1;
    unique case (lw_pin)
      fsp_pkg::LW_2: val = {2'h0, sh_d[31:30]};
      fsp_pkg::LW_4: val = sh_d[31:28];
      default: val = {3'h0, sh_d[31]};
    endcase
    unique case (lw_pin)
      fsp_pkg::LW_2: drive = fsp_pkg::DQ_L01;
      fsp_pkg::LW_4: drive = fsp_pkg::DQ_ALL;
      default: drive = fsp_pkg::DQ_L0;
    endcase
    if (state_d inside {ST_IDLE, ST_END}) begin
      val = fsp_pkg::DQ_NONE;
    end else if (state_d == ST_DUMMY || (state_d == ST_DATA && !cmd_q.write)) begin
      val = fsp_pkg::DQ_NONE;
      drive = lwd == fsp_pkg::LW_1 ? fsp_pkg::DQ_L0 : fsp_pkg::DQ_NONE;
    end
    pins_d.clk = sclk_d;
    pins_d.clk_oe_n = 1'b0;
    pins_d.cs_n = sel_d;
    pins_d.cs_oe_n = 1'b0;
    pins_d.dq = val & drive;
    pins_d.dq_oe_n = ~drive;
    if (!rel_q) begin
      pins_d = fsp_pkg::PINS_OFF;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      cmd_q <= '0;
      sh_q <= 32'h0;
      cnt_q <= fsp_pkg::CNT_ZERO;
      in_q <= 8'h0;
      bits_q <= fsp_pkg::BITS_ZERO;
      left_q <= fsp_pkg::CNT_ZERO;
      need_q <= 1'b0;
      sclk_q <= 1'b0;
      sel_q <= fsp_pkg::CS_NONE;
      rsm1_q <= 1'b0;
      rel_q <= 1'b0;
      dq_s1_q <= fsp_pkg::DQ_NONE;
      dq_s_q <= fsp_pkg::DQ_NONE;
      bidir_q <= 1'b0;
      tpm_q <= 1'b0;
      pins_o <= fsp_pkg::PINS_OFF;
      req_ready_o <= 1'b0;
      wr_take_o <= 1'b0;
      rd_valid_o <= 1'b0;
      rd_data_o <= 8'h0;
      done_o <= 1'b0;
      err_o <= 1'b0;
    end else begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      in_q <= in_d;
      bits_q <= bits_d;
      left_q <= left_d;
      need_q <= need_d;
      sclk_q <= sclk_d;
      sel_q <= sel_d;
      rsm1_q <= resume_well_reset_n_i;
      rel_q <= rsm1_q;
      dq_s1_q <= dq_i;
      dq_s_q <= dq_s1_q;
      bidir_q <= bidir_d;
      tpm_q <= tpm_d;
      pins_o <= pins_d;
      req_ready_o <= ready_d;
      wr_take_o <= take_d;
      rd_valid_o <= rdv_d;
      rd_data_o <= rdd_d;
      done_o <= done_d;
      err_o <= err_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_take_tpm_off;
    req_valid_i && req_ready_o && req_i.target == fsp_pkg::TGT_TPM && !tpm_q;
  endsequence
  sequence s_take_far_addr;
    req_valid_i && req_ready_o && !req_i.addr4 && req_i.addr[25:24] != fsp_pkg::ADDR_HI_ZERO;
  endsequence
  sequence s_refused;
    err_o && pins_o.cs_n == fsp_pkg::CS_NONE ##1 pins_o.cs_n == fsp_pkg::CS_NONE;
  endsequence

  a_cs_onehot: assert property ($countones(~pins_o.cs_n) <= 1)
    else $error("more than one select asserted");
  a_cs_primary: assert property (!pins_o.cs_n[0] |-> cmd_q.target == fsp_pkg::TGT_PRI)
    else $error("primary select used for another target");
  a_cs_secondary: assert property (!pins_o.cs_n[1] |-> cmd_q.target == fsp_pkg::TGT_SEC)
    else $error("secondary select used for another target");
  a_cs_tpm: assert property (!pins_o.cs_n[2] |-> tpm_q && cmd_q.mode == fsp_pkg::M_SINGLE)
    else $error("module select without strap or with multi-lane mode");
  a_tpm_refused: assert property (s_take_tpm_off |=> s_refused)
    else $error("module request not refused while strapped away");
  a_addr_range: assert property (s_take_far_addr |=> s_refused)
    else $error("three-byte address above 16 MB not refused");
  a_clk_framed: assert property ($changed(pins_o.clk) && !pins_o.clk_oe_n |->
      pins_o.cs_n != fsp_pkg::CS_NONE)
    else $error("serial clock toggled with no select");
  a_lane0_out: assert property (!bidir_q && $past(rel_q) && pins_o.dq_oe_n[0] |->
      cmd_q.mode == fsp_pkg::M_DUAL_OUT && state_q inside {ST_DUMMY, ST_DATA})
    else $error("lane zero released outside dual output read");
  a_lane1_in: assert property (!bidir_q |-> pins_o.dq_oe_n[1])
    else $error("lane one driven without strap");
  a_upper_free: assert property (cmd_q.mode != fsp_pkg::M_QUAD_IO |-> &pins_o.dq_oe_n[3:2])
    else $error("upper lanes driven outside quad I/O");
  a_held_off: assert property (!rel_q |=> pins_o.clk_oe_n && pins_o.cs_oe_n &&
      pins_o.dq_oe_n == fsp_pkg::DQ_ALL)
    else $error("pins driven before resume reset release");
  a_idle_levels: assert property ($past(rel_q) && state_q == ST_IDLE |-> !pins_o.clk &&
      !pins_o.clk_oe_n && pins_o.cs_n == fsp_pkg::CS_NONE && pins_o.dq_oe_n == 4'he &&
      !pins_o.dq[0])
    else $error("idle pin levels wrong");

endmodule

`default_nettype wire

// ### testbench/fsp_flash_model.sv
/*
  Far-side model: serial flash or trusted module answering reads on the port.
  Assumes the bench sets lane count, data start cycle and data seed per transfer.
*/
`default_nettype none

module fsp_flash_model (
  input wire fsp_pkg::fsp_pins_t pins_i,
  input wire logic [3:0] line_i,
  input wire logic [1:0] lanes_i,
  input wire logic [7:0] start_i,
  input wire logic [7:0] base_i,
  output logic [3:0] drv_o,
  output logic [3:0] en_o,
  output logic [95:0] shreg_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sel;
  logic [7:0] ncyc;
  logic [7:0] b;
  int w;
  int j;
  int k;
  assign sel = !pins_i.cs_oe_n && pins_i.cs_n != fsp_pkg::CS_NONE;
  assign w = lanes_i == fsp_pkg::LW_4 ? 4 : lanes_i == fsp_pkg::LW_2 ? 2 : 1;

  ////////////////////////////////////////////////////////////////////////////
  // Count clock rises, capture lane zero MSB first
  always @(posedge pins_i.clk or negedge sel) begin
    if (!sel) begin
      ncyc <= 8'h00;
    end else begin
      ncyc <= ncyc + 8'h01;
      shreg_o <= {shreg_o[94:0], line_i[0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift read data out after each falling clock from the data start cycle on; lines released when deselected
  always @(negedge pins_i.clk or negedge sel) begin
    if (!sel) begin
      en_o <= 4'h0;
    end else if (ncyc >= start_i) begin
      j = int'(ncyc - start_i) * w;
      b = base_i + 8'(j / 8) * 8'h11;
      k = (int'(b) >> (8 - w - j % 8)) & ((1 << w) - 1);
      drv_o <= w == 1 ? 4'(k << 1) : 4'(k);
      en_o <= w == 4 ? 4'hf : w == 2 ? 4'h3 : 4'h2;
    end
  end
endmodule

`default_nettype wire

// ### testbench/tb.sv
/*
  Self-checking bench for the serial port master: random reads, writes, refusals.
  Assumes fsp_flash_model on the pins and a 10 MHz system clock.
*/
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic rsm_n = 1'b0;
  logic sleep_i = 1'b0;
  logic bidir = 1'b0;
  logic tpm = 1'b1;
  logic req_valid_i = 1'b0;
  fsp_pkg::fsp_cmd_t req_i = '0;
  logic wr_valid_i = 1'b0;
  logic [7:0] wr_data_i = 8'h00;
  logic req_ready_o;
  logic wr_take_o;
  logic rd_valid_o;
  logic [7:0] rd_data_o;
  logic done_o;
  logic err_o;
  logic [3:0] dq_i;
  fsp_pkg::fsp_pins_t pins_o;
  logic [3:0] m_drv;
  logic [3:0] m_en;
  logic [1:0] m_lanes = 2'h0;
  logic [7:0] m_start = 8'h00;
  logic [7:0] m_base = 8'h00;
  logic [95:0] shreg;
  logic [7:0] rdq[$];
  logic [7:0] wq[$];
  int wr_idx = 0;
  int errs = 0;
  int dones = 0;
  int fails = 0;
  int comparisons = 0;
  int gap = 0;
  int gmin = 255;
  logic clk_prev = 1'b0;
  logic [2:0] sel_seen = 3'h0;
  logic multi = 1'b0;
  logic up_used = 1'b0;

  // All lanes carry pull-ups when nobody drives them
  assign dq_i = (~pins_o.dq_oe_n & pins_o.dq) | (pins_o.dq_oe_n & ((m_en & m_drv) | ~m_en));

  fsp_port dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .resume_well_reset_n_i(rsm_n),
    .sleep_i(sleep_i), .bidir_strap_i(bidir), .tpm_strap_i(tpm), .req_valid_i(req_valid_i),
    .req_i(req_i), .req_ready_o(req_ready_o), .wr_valid_i(wr_valid_i), .wr_data_i(wr_data_i),
    .wr_take_o(wr_take_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .done_o(done_o),
    .err_o(err_o), .dq_i(dq_i), .pins_o(pins_o));
  fsp_flash_model partner (.pins_i(pins_o), .line_i(dq_i), .lanes_i(m_lanes),
    .start_i(m_start), .base_i(m_base), .drv_o(m_drv), .en_o(m_en), .shreg_o(shreg));

  initial begin
    forever #50 mclk_i = ~mclk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Monitor and write-data feeder
  always @(negedge mclk_i) begin
    if (err_o === 1'b1) errs++;
    if (done_o === 1'b1) dones++;
    if (rd_valid_o === 1'b1) rdq.push_back(rd_data_o);
    if (wr_take_o === 1'b1) wr_idx++;
    wr_valid_i <= wr_idx < wq.size();
    wr_data_i <= wr_idx < wq.size() ? wq[wr_idx] : 8'h00;
    if (pins_o.cs_oe_n === 1'b0) sel_seen |= ~pins_o.cs_n;
    if ($countones(~pins_o.cs_n) > 1) multi = 1'b1;
    if (pins_o.dq_oe_n[3:2] !== 2'h3) up_used = 1'b1;
    gap++;
    if (pins_o.clk === 1'b1 && clk_prev === 1'b0) begin
      if (gap < gmin) gmin = gap;
      gap = 0;
    end
    clk_prev = pins_o.clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks and helpers
  task automatic test_done();
    if (fails == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk_flag(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask

  task automatic chk_word(input logic [63:0] got, input logic [63:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask

  function automatic logic [7:0] exp_rd(input logic [7:0] b, input int k);
    return b + 8'(k) * 8'h11;
  endfunction

  function automatic int half_of(input logic [1:0] r);
    if (r == fsp_pkg::RATE_SEL_48) return int'(fsp_pkg::HALF_48);
    if (r == fsp_pkg::RATE_SEL_30) return int'(fsp_pkg::HALF_30);
    return int'(fsp_pkg::HALF_17);
  endfunction

  function automatic fsp_pkg::fsp_cmd_t rnd_cmd(input int t, input int md);
    fsp_pkg::fsp_cmd_t c;
    c = fsp_pkg::fsp_cmd_t'({$urandom, $urandom});
    c.rate = 2'($urandom_range(2));
    c.target = 2'(t);
    c.mode = fsp_pkg::fsp_mode_t'(md);
    c.write = 1'b0;
    if (!c.addr4) c.addr[25:24] = 2'h0;
    c.dummy = 8'($urandom_range(8));
    c.len = 8'($urandom_range(4, 1));
    return c;
  endfunction

  task automatic wait_ready();
    int n;
    n = 0;
    while (req_ready_o !== 1'b1 && n < 100) begin
      @(negedge mclk_i);
      n++;
    end
    if (n == 100) begin
      fails++;
      test_done();
    end
  endtask

  task automatic launch(input fsp_pkg::fsp_cmd_t c);
    wait_ready();
    req_i <= c;
    req_valid_i <= 1'b1;
    @(negedge mclk_i);
    req_valid_i <= 1'b0;
  endtask

  task automatic xfer(input fsp_pkg::fsp_cmd_t c, input logic bad);
    int n;
    int e0;
    int d0;
    e0 = errs;
    d0 = dones;
    gmin = 255;
    sel_seen = 3'h0;
    rdq.delete();
    launch(c);
    n = 0;
    while (errs == e0 && dones == d0 && n < 3000) begin
      @(negedge mclk_i);
      n++;
    end
    if (n == 3000) begin
      fails++;
      test_done();
    end
    chk_flag(errs != e0, bad, "refusal");
  endtask

  task automatic chk_hdr(input fsp_pkg::fsp_cmd_t c, input logic [95:0] h);
    logic [39:0] m;
    m = c.addr4 ? 40'hff_ffff_ffff : 40'h00_ffff_ffff;
    chk_word(h[39:0] & m, c.addr4 ? {c.opcode, 6'h00, c.addr} : {8'h00, c.opcode, c.addr[23:0]},
      "opcode and address");
  endtask

  task automatic chk_idle();
    chk_word({pins_o.clk, pins_o.clk_oe_n, pins_o.cs_n, pins_o.cs_oe_n}, 6'h0e, "idle");
    chk_word({pins_o.dq[0], pins_o.dq_oe_n}, 5'h0e, "idle lanes");
  endtask

  task automatic rd_xfer(input fsp_pkg::fsp_cmd_t c);
    int ab;
    int w;
    ab = c.addr4 ? 32 : 24;
    w = c.mode == fsp_pkg::M_DUAL_OUT || c.mode == fsp_pkg::M_DUAL_IO ? 2 :
      c.mode >= fsp_pkg::M_QUAD_OUT ? 4 : 1;
    m_lanes = w == 4 ? fsp_pkg::LW_4 : w == 2 ? fsp_pkg::LW_2 : fsp_pkg::LW_1;
    m_start = 8'(8 + c.dummy + (c.mode == fsp_pkg::M_DUAL_IO ? ab / 2 :
      c.mode == fsp_pkg::M_QUAD_IO ? ab / 4 : ab));
    m_base = 8'($urandom);
    xfer(c, 1'b0);
    chk_word(64'(rdq.size()), 64'(c.len), "read count");
    foreach (rdq[i]) chk_word(rdq[i], exp_rd(m_base, i), "read byte");
    chk_word(sel_seen, 3'h1 << c.target, "select line");
    chk_word(64'(gmin), 64'(2 * half_of(c.rate)), "serial clock period");
    if (c.mode != fsp_pkg::M_DUAL_IO && c.mode != fsp_pkg::M_QUAD_IO)
      chk_hdr(c, shreg >> (c.dummy + c.len * 8 / w + 1));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    fsp_pkg::fsp_cmd_t c;
    int d;
    void'($urandom(99));
    repeat (6) @(negedge mclk_i);
    chk_word(64'(pins_o), 64'(fsp_pkg::PINS_OFF), "pins off in reset");
    rst_n_i <= 1'b1;
    repeat (4) @(negedge mclk_i);
    chk_word(64'(pins_o), 64'(fsp_pkg::PINS_OFF), "pins off before resume");
    rsm_n <= 1'b1;
    wait_ready();
    up_used = 1'b0;
    multi = 1'b0;
    chk_idle();
    sleep_i <= 1'b1;
    repeat (3) @(negedge mclk_i);
    chk_flag(req_ready_o, 1'b0, "ready in sleep");
    chk_idle();
    sleep_i <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      c = rnd_cmd(0, 0);
      case (i)
        0: c.target = 2'h3;
        1: c.mode = fsp_pkg::fsp_mode_t'(3'h5);
        2: c.rate = 2'h3;
        3: c.target = fsp_pkg::TGT_TPM;
        4: c.mode = fsp_pkg::M_QUAD_IO;
        default: c.addr[25:24] = 2'h1;
      endcase
      if (i == 3) c.mode = fsp_pkg::M_DUAL_OUT;
      if (i == 5) c.addr4 = 1'b0;
      xfer(c, 1'b1);
      chk_word(sel_seen, 3'h0, "select on refusal");
    end
    for (int i = 0; i < 6; i++) begin
      c = rnd_cmd(i < 3 ? i : i % 2, i < 3 ? 0 : 1);
      c.rate = 2'(i % 3);
      rd_xfer(c);
    end
    c = rnd_cmd(0, 0);
    c.addr4 = 1'b0;
    c.addr = 26'h0ff_ffff;
    rd_xfer(c);
    c = rnd_cmd(1, 0);
    c.write = 1'b1;
    c.addr4 = 1'b1;
    c.addr = 26'h3ff_ffff;
    c.dummy = 8'h00;
    c.len = 8'h02;
    wq = '{8'($urandom), 8'($urandom)};
    wr_idx = 0;
    xfer(c, 1'b0);
    chk_word(shreg[15:0], {wq[0], wq[1]}, "write bytes");
    chk_hdr(c, shreg >> 16);
    wq.delete();
    chk_flag(up_used, 1'b0, "upper lanes idle");
    c = rnd_cmd(0, 0);
    c.len = 8'h08;
    launch(c);
    repeat (20) @(negedge mclk_i);
    d = dones;
    rsm_n <= 1'b0;
    bidir <= 1'b1;
    tpm <= 1'b0;
    repeat (4) @(negedge mclk_i);
    chk_word(64'(pins_o), 64'(fsp_pkg::PINS_OFF), "pins off on abort");
    rsm_n <= 1'b1;
    wait_ready();
    chk_word(64'(dones), 64'(d), "done after abort");
    xfer(rnd_cmd(2, 0), 1'b1);
    for (int i = 1; i < 5; i++) begin
      rd_xfer(rnd_cmd(i % 2, i));
    end
    chk_flag(up_used, 1'b1, "upper lanes in quad");
    chk_flag(multi, 1'b0, "one select at a time");
    test_done();
  end
endmodule

`default_nettype wire
